// >>> design/bct_top.sv
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module bct_top (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Wishbone slave
  input wire bct_pkg::bct_wb_req_s wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // CPU pipeline events
  input wire bct_pkg::bct_cpu_s cpu_i,
  // Break request and channel space ids
  output logic break_o,
  output logic [bct_pkg::ASID_W-1:0] space_id_a_o,
  output logic [bct_pkg::ASID_W-1:0] space_id_b_o
);
  import bct_pkg::*;

  bct_state_s r_reg, r_next;
  logic [ASID_W-1:0] asid_a_reg, asid_b_reg;
  logic req;
  logic wr;
  logic rd;
  logic push;
  logic [PTR_W-1:0] enc_ptr;
  logic [PTR_W-1:0] push_ptr;
  logic [ADDR_W-1:0] push_src;
  logic [IDX_W-1:0] q_idx;
  logic [IDX_W-1:0] clr_idx;
  logic clr_src, clr_dst;
  logic [ADDR_W+PTR_W:0] src_rd;
  logic [ADDR_W:0] dst_rd;
  logic [31:0] rd_word;

  // Buffer number to decode pointer: even names itself, odd stands two above
  function automatic logic [PTR_W-1:0] enc_buf(input logic [3:0] b);
    logic [3:0] t;
    t = b[0] ? (b - 4'h2) : b;
    return t[PTR_W-1:0];
  endfunction

  assign req = wb_i.cyc && wb_i.stb && !r_reg.ack;
  assign wr = (r_reg.bus == BCT_RESP) && wb_i.we;
  assign rd = (r_reg.bus == BCT_RESP) && !wb_i.we;
  assign enc_ptr = enc_buf(cpu_i.buf_num);

  // A destination fetch closes the branch and pushes both queues together
  assign push = r_reg.trace_en && cpu_i.fetch_valid && (r_reg.pend_valid || cpu_i.branch);
  assign push_src = cpu_i.branch ? r_reg.last_fetch : r_reg.pend_src;
  assign push_ptr = cpu_i.branch ? enc_ptr : r_reg.pend_ptr;

  // Older positions sit in their own windows
  assign q_idx = (wb_i.adr[7:5] == WIN_SRC_Q || wb_i.adr[7:5] == WIN_DST_Q) ? wb_i.adr[4:2] : '0;

  // The head read was sampled before any shift; follow it down the queue
  assign clr_idx = IDX_W'({2'b00, r_reg.shift_seen} + {2'b00, push});
  assign clr_src = rd && r_reg.adr == ADR_SRC;
  assign clr_dst = rd && r_reg.adr == ADR_DST;

  bct_trace_queue #(
    .W(ADDR_W + PTR_W),
    .DEPTH(DEPTH),
    .IW(IDX_W)
  ) u_src_q (
    .clk(clk),
    .resetn(resetn),
    .push(push),
    .push_data({push_ptr, push_src}),
    .clr(clr_src),
    .clr_idx(clr_idx),
    .rd_idx(q_idx),
    .rd_data(src_rd)
  );

  bct_trace_queue #(
    .W(ADDR_W),
    .DEPTH(DEPTH),
    .IW(IDX_W)
  ) u_dst_q (
    .clk(clk),
    .resetn(resetn),
    .push(push),
    .push_data(cpu_i.fetch_addr),
    .clr(clr_dst),
    .clr_idx(clr_idx),
    .rd_idx(q_idx),
    .rd_data(dst_rd)
  );

  // Read data of the addressed register
  always_comb begin
    rd_word = DAT_RST;
    if (r_reg.adr[7:5] == WIN_SRC_Q) begin
      rd_word = {src_rd[ADDR_W+PTR_W], src_rd[ADDR_W+PTR_W-1:0]};
    end else if (r_reg.adr[7:5] == WIN_DST_Q) begin
      rd_word = {dst_rd[ADDR_W], 3'h0, dst_rd[ADDR_W-1:0]};
    end else begin
      unique case (r_reg.adr)
        ADR_COUNT: rd_word = {20'h00000, r_reg.count};
        ADR_SRC: rd_word = {src_rd[ADDR_W+PTR_W], src_rd[ADDR_W+PTR_W-1:0]};
        ADR_DST: rd_word = {dst_rd[ADDR_W], 3'h0, dst_rd[ADDR_W-1:0]};
        ADR_ASID_A: rd_word = {24'h000000, asid_a_reg};
        ADR_ASID_B: rd_word = {24'h000000, asid_b_reg};
        ADR_CTRL: rd_word = {30'h00000000, r_reg.trace_en, r_reg.cnt_en};
        default: rd_word = DAT_RST;
      endcase
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.brk = 1'b0;
    // Bus sequencing: request seen, then answer two cycles later
    unique case (r_reg.bus)
      BCT_IDLE: begin
        if (req) begin
          r_next.bus = BCT_RESP;
          r_next.adr = {wb_i.adr[7:2], 2'b00};
          r_next.shift_seen = push;
        end
      end
      BCT_RESP: begin
        r_next.bus = BCT_IDLE;
        r_next.ack = 1'b1;
        r_next.dat = wb_i.we ? DAT_RST : rd_word;
      end
      default: r_next.bus = BCT_IDLE;
    endcase
    // Execution-count break on channel B
    if (cpu_i.cond_b) begin
      r_next.brk = !r_reg.cnt_en || r_reg.count == COUNT_LAST;
      if (r_reg.cnt_en && r_reg.count != COUNT_RST) begin
        r_next.count = r_reg.count - COUNT_LAST;
      end
    end
    // Software writes win over a decrement in the same cycle
    if (wr && r_reg.adr == ADR_COUNT) begin
      if (wb_i.sel[0]) begin
        r_next.count[7:0] = wb_i.dat[7:0];
      end
      if (wb_i.sel[1]) begin
        r_next.count[11:8] = wb_i.dat[11:8];
      end
    end
    if (wr && r_reg.adr == ADR_CTRL && wb_i.sel[0]) begin
      r_next.cnt_en = wb_i.dat[CTRL_CNT_EN_BIT];
      r_next.trace_en = wb_i.dat[CTRL_TRACE_EN_BIT];
    end
    // Fetch stream tracking for the trace
    if (cpu_i.fetch_valid) begin
      r_next.last_fetch = cpu_i.fetch_addr;
    end
    if (push) begin
      r_next.pend_valid = 1'b0;
    end else if (r_reg.trace_en && cpu_i.branch) begin
      r_next.pend_valid = 1'b1;
      r_next.pend_src = r_reg.last_fetch;
      r_next.pend_ptr = enc_ptr;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '{bus: BCT_IDLE, dat: DAT_RST, count: COUNT_RST, last_fetch: '0, pend_src: '0, pend_ptr: '0,
                 adr: '0, default: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Space id registers hold through any reset
  always_ff @(posedge clk) begin
    if (wr && r_reg.adr == ADR_ASID_A && wb_i.sel[0]) begin
      asid_a_reg <= wb_i.dat[ASID_W-1:0];
    end
    if (wr && r_reg.adr == ADR_ASID_B && wb_i.sel[0]) begin
      asid_b_reg <= wb_i.dat[ASID_W-1:0];
    end
  end

  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.dat;
  assign break_o = r_reg.brk;
  assign space_id_a_o = asid_a_reg;
  assign space_id_b_o = asid_b_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic cnt_wr;
  assign cnt_wr = wr && r_reg.adr == ADR_COUNT;

  count_fire_a: assert property (r_reg.cnt_en && cpu_i.cond_b && r_reg.count == COUNT_LAST |=> break_o)
    else $error("no break at count one");
  count_hold_a: assert property (r_reg.cnt_en && cpu_i.cond_b && r_reg.count != COUNT_LAST |=> !break_o)
    else $error("break before count one");
  count_dec_a: assert property (r_reg.cnt_en && cpu_i.cond_b && r_reg.count > COUNT_LAST && !cnt_wr
    |=> r_reg.count == $past(r_reg.count) - COUNT_LAST) else $error("count not decremented");
  count_mask_a: assert property (!r_reg.cnt_en && cpu_i.cond_b && !cnt_wr |=> break_o && $stable(r_reg.count))
    else $error("masked count misbehaves");
  count_top_a: assert property (wb_ack_o && r_reg.adr == ADR_COUNT |-> wb_dat_o[31:12] == 20'h00000)
    else $error("count upper bits not zero");
  dst_resv_a: assert property (wb_ack_o && r_reg.adr == ADR_DST |-> wb_dat_o[30:28] == 3'h0)
    else $error("reserved bits not zero");
  trace_gate_a: assert property (!r_reg.trace_en |-> !push) else $error("capture while trace off");
  // The head check only holds while the bus addresses position 0
  src_latest_a: assert property (push ##1 (!push && q_idx == '0) ##1 !push |-> src_rd[ADDR_W-1:0] == $past(push_src, 2))
    else $error("head not newest source");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_time_a: assert property (req && r_reg.bus == BCT_IDLE |=> ##1 wb_ack_o) else $error("late ack");

  // A branch without a fetch parks the source until the destination arrives
  pend_src_a: assert property (r_reg.trace_en && cpu_i.branch && !push
    |=> r_reg.pend_valid && r_reg.pend_src == $past(r_reg.last_fetch))
    else $error("pending source not captured");
  pend_ptr_a: assert property (r_reg.trace_en && cpu_i.branch && !push
    |=> r_reg.pend_ptr == $past(enc_ptr))
    else $error("pending pointer not captured");

  // Pointer encoding for buffers that fit the three-bit field
  ptr_even_a: assert property (!cpu_i.buf_num[3] && !cpu_i.buf_num[0] |-> enc_ptr == cpu_i.buf_num[PTR_W-1:0])
    else $error("even pointer wrong");
  ptr_odd_a: assert property (!cpu_i.buf_num[3] && cpu_i.buf_num[0]
    |-> PTR_W'(enc_ptr + 3'h2) == cpu_i.buf_num[PTR_W-1:0])
    else $error("odd pointer wrong");

  // A pushed entry shows up at the head two edges later with its flag set
  src_ptr_a: assert property (push ##1 (q_idx == '0)
    |=> src_rd[ADDR_W+PTR_W-1:ADDR_W] == $past(push_ptr, 2))
    else $error("head pointer not newest");
  src_flag_a: assert property (push ##1 (q_idx == '0) |=> src_rd[ADDR_W+PTR_W])
    else $error("source flag not set");
  dst_addr_a: assert property (push ##1 (q_idx == '0)
    |=> dst_rd[ADDR_W-1:0] == $past(cpu_i.fetch_addr, 2))
    else $error("destination not first fetch");
  dst_flag_a: assert property (push ##1 (q_idx == '0) |=> dst_rd[ADDR_W])
    else $error("destination flag not set");
  push_fetch_a: assert property (push |-> cpu_i.fetch_valid)
    else $error("push without a fetch");

  // Register writes land on the acknowledging edge
  count_wr_a: assert property (cnt_wr && wb_i.sel[1:0] == 2'b11
    |=> r_reg.count == $past(wb_i.dat[COUNT_W-1:0]))
    else $error("count write lost");
  count_zero_a: assert property (r_reg.cnt_en && cpu_i.cond_b && r_reg.count == COUNT_RST && !cnt_wr
    |=> r_reg.count == COUNT_RST && !break_o)
    else $error("count wrapped below zero");
  ctrl_wr_a: assert property (wr && r_reg.adr == ADR_CTRL && wb_i.sel[0]
    |=> r_reg.cnt_en == $past(wb_i.dat[CTRL_CNT_EN_BIT]) && r_reg.trace_en == $past(wb_i.dat[CTRL_TRACE_EN_BIT]))
    else $error("control write lost");
  asid_a_wr_a: assert property (wr && r_reg.adr == ADR_ASID_A && wb_i.sel[0]
    |=> space_id_a_o == $past(wb_i.dat[ASID_W-1:0]))
    else $error("space id A write lost");
  asid_b_wr_a: assert property (wr && r_reg.adr == ADR_ASID_B && wb_i.sel[0]
    |=> space_id_b_o == $past(wb_i.dat[ASID_W-1:0]))
    else $error("space id B write lost");
  asid_top_a: assert property (wb_ack_o && (r_reg.adr == ADR_ASID_A || r_reg.adr == ADR_ASID_B)
    |-> wb_dat_o[31:ASID_W] == 24'h000000)
    else $error("space id upper bits not zero");
  brk_cause_a: assert property (break_o |-> $past(cpu_i.cond_b))
    else $error("break without a match");

  brk_c: cover property (r_reg.cnt_en && cpu_i.cond_b && r_reg.count == COUNT_LAST ##1 break_o);
  push_c: cover property (push ##1 push);
  rdclr_c: cover property (clr_src && src_rd[ADDR_W+PTR_W]);
  dst_c: cover property (clr_dst && push);
  mask_c: cover property (!r_reg.cnt_en && cpu_i.cond_b ##1 break_o);
endmodule

// >>> design/bct_pkg.sv
package bct_pkg;
  // Register byte addresses on the Wishbone slave
  localparam logic [7:0] ADR_COUNT = 8'h00;
  localparam logic [7:0] ADR_SRC = 8'h04;
  localparam logic [7:0] ADR_DST = 8'h08;
  localparam logic [7:0] ADR_ASID_A = 8'h0C;
  localparam logic [7:0] ADR_ASID_B = 8'h10;
  localparam logic [7:0] ADR_CTRL = 8'h14;
  // Windows onto all eight queue positions, one word each, no side effect
  localparam logic [2:0] WIN_SRC_Q = 3'h2;
  localparam logic [2:0] WIN_DST_Q = 3'h3;

  // Field layout
  localparam int COUNT_W = 12;
  localparam int ADDR_W = 28;
  localparam int PTR_W = 3;
  localparam int ASID_W = 8;
  localparam int DEPTH = 8;
  localparam int IDX_W = 3;
  localparam int VALID_BIT = 31;
  localparam int PTR_LSB = 28;
  localparam int CTRL_CNT_EN_BIT = 0;
  localparam int CTRL_TRACE_EN_BIT = 1;

  // Values after reset, and the count at which a match breaks
  localparam logic [COUNT_W-1:0] COUNT_RST = 12'h000;
  localparam logic [COUNT_W-1:0] COUNT_LAST = 12'h001;
  localparam logic [31:0] DAT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    BCT_IDLE = 2'b01,
    BCT_RESP = 2'b10
  } bct_bus_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } bct_wb_req_s;

  typedef struct packed {
    logic cond_b;
    logic fetch_valid;
    logic [ADDR_W-1:0] fetch_addr;
    logic branch;
    logic [3:0] buf_num;
  } bct_cpu_s;

  typedef struct packed {
    bct_bus_e bus;
    logic ack;
    logic [31:0] dat;
    logic [7:0] adr;
    logic shift_seen;
    logic [COUNT_W-1:0] count;
    logic cnt_en;
    logic trace_en;
    logic brk;
    logic [ADDR_W-1:0] last_fetch;
    logic pend_valid;
    logic [ADDR_W-1:0] pend_src;
    logic [PTR_W-1:0] pend_ptr;
  } bct_state_s;
endpackage

// >>> design/bct_trace_queue.sv
`timescale 1ns/1ps
module bct_trace_queue #(
  parameter int W = 31,
  parameter int DEPTH = 8,
  parameter int IW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Push side
  input wire logic push,
  input wire logic [W-1:0] push_data,
  // Valid clear after a head read
  input wire logic clr,
  input wire logic [IW-1:0] clr_idx,
  // Read port, registered
  input wire logic [IW-1:0] rd_idx,
  output logic [W:0] rd_data
);
  logic [W-1:0] data_q [DEPTH];
  logic [DEPTH-1:0] valid_q;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      logic v_in;
      logic [W-1:0] d_in;
      if (i == 0) begin : g_head
        assign v_in = 1'b1;
        assign d_in = push_data;
      end else begin : g_tail
        assign v_in = valid_q[i-1];
        assign d_in = data_q[i-1];
      end
      // Address and pointer fields are never reset
      always_ff @(posedge clk) begin
        if (push) begin
          data_q[i] <= d_in;
        end
      end
      // Only the valid flags are cleared by reset; a new entry wins over a clear
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          valid_q[i] <= 1'b0;
        end else if (clr && clr_idx == IW'(i) && !(push && i == 0)) begin
          valid_q[i] <= 1'b0;
        end else if (push) begin
          valid_q[i] <= v_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= {valid_q[rd_idx], data_q[rd_idx]};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  push_valid_a: assert property (push |=> valid_q[0]) else $error("new head entry not valid");
  shift_data_a: assert property (push && valid_q[0] |=> data_q[1] == $past(data_q[0]))
    else $error("queue did not shift");
  clr_flag_a: assert property (clr && !push |=> !valid_q[$past(clr_idx)]) else $error("read did not clear flag");
endmodule

// >>> dv/bct_cpu_model.sv
`timescale 1ns/1ps
module bct_cpu_model (
  // Clock
  input wire logic clk,
  // Pipeline events toward the break unit
  output bct_pkg::bct_cpu_s cpu
);
  import bct_pkg::*;
  initial cpu = '0;
  // Idle lines change every time, so a stale fetch address is never reused
  task automatic idle();
    @(posedge clk);
    cpu <= '{1'b0, 1'b0, ~cpu.fetch_addr, 1'b0, ~cpu.buf_num};
  endtask
  task automatic match();
    @(posedge clk);
    cpu.cond_b <= 1'b1;
    idle();
  endtask
  task automatic fetch(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    cpu.fetch_valid <= 1'b1;
    cpu.fetch_addr <= a;
    idle();
  endtask
  // Any branch, repeat or interrupt
  task automatic branch(input logic [3:0] b);
    @(posedge clk);
    cpu.branch <= 1'b1;
    cpu.buf_num <= b;
    idle();
  endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bct_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  bct_wb_req_s wbr = '0;
  bct_cpu_s cpu;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic break_o;
  logic [ASID_W-1:0] sid_a;
  logic [ASID_W-1:0] sid_b;
  int err_total = 0;
  int num_checks = 0;
  int brk_cnt = 0;
  logic [31:0] q;
  logic [31:0] src_q [DEPTH];
  logic [31:0] dst_q [DEPTH];
  always #5 clk = ~clk;
  always @(posedge clk) if (break_o === 1'b1) brk_cnt++;
  bct_top bct_top_i (.clk(clk), .resetn(resetn), .wb_i(wbr), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .cpu_i(cpu), .break_o(break_o), .space_id_a_o(sid_a), .space_id_b_o(sid_b));
  bct_cpu_model bct_cpu_model_i (.clk(clk), .cpu(cpu));
  function automatic logic [2:0] enc_ptr(input logic [2:0] b);
    return b[0] ? b - 3'h2 : b;
  endfunction
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wbr <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      results();
    end
    r = wb_dat_o;
    wbr <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
  endtask
  // One branch; the expected queues shift only when tracing is on
  task automatic trace_one(input logic en, input logic [27:0] s, input logic [2:0] b, input logic [27:0] d);
    bct_cpu_model_i.fetch(s);
    bct_cpu_model_i.branch({1'b0, b});
    bct_cpu_model_i.fetch(d);
    if (en) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        src_q[i] = src_q[i-1];
        dst_q[i] = dst_q[i-1];
      end
      src_q[0] = {1'b1, enc_ptr(b), s};
      dst_q[0] = {1'b1, 3'h0, d};
    end
  endtask
  task automatic match_n(input int n);
    repeat (n) bct_cpu_model_i.match();
    repeat (2) @(posedge clk);
  endtask
  initial begin
    logic [7:0] ida;
    logic [7:0] idb;
    int n;
    int b0;
    void'($urandom(60315));
    do_reset();
    rd(ADR_CTRL, 32'h0);
    rd(ADR_COUNT, 32'h0);
    wb(1'b0, ADR_SRC, 32'h0, q);
    chk({31'h0, q[VALID_BIT]}, 32'h0);
    rd(8'h2C, 32'h0);
    ida = 8'($urandom);
    idb = 8'($urandom);
    wr(ADR_ASID_A, {24'h0, ida});
    wr(ADR_ASID_B, {24'h0, idb});
    rd(ADR_ASID_A, {24'h0, ida});
    rd(ADR_ASID_B, {24'h0, idb});
    chk({16'h0, sid_a, sid_b}, {16'h0, ida, idb});
    wr(ADR_CTRL, 32'h1);
    wr(ADR_COUNT, 32'h0FFF);
    rd(ADR_COUNT, 32'h0FFF);
    for (int k = 0; k < 4; k++) begin
      n = (k == 0) ? 1 : (k == 1) ? 2 : 3 + int'($urandom % 7);
      wr(ADR_COUNT, 32'(n));
      b0 = brk_cnt;
      match_n(n - 1);
      chk(32'(brk_cnt), 32'(b0));
      rd(ADR_COUNT, 32'h1);
      match_n(1);
      chk(32'(brk_cnt), 32'(b0 + 1));
      rd(ADR_COUNT, 32'h0);
    end
    wr(ADR_CTRL, 32'h0);
    wr(ADR_COUNT, 32'h5);
    b0 = brk_cnt;
    match_n(1);
    chk(32'(brk_cnt), 32'(b0 + 1));
    rd(ADR_COUNT, 32'h5);
    wr(ADR_CTRL, 32'h2);
    for (int k = 0; k < 10; k++)
      trace_one(1'b1, 28'($urandom), (k < 8) ? 3'(k) : 3'($urandom), 28'($urandom));
    for (int i = 0; i < DEPTH; i++) begin
      rd({WIN_SRC_Q, 3'(i), 2'b00}, src_q[i]);
      rd({WIN_DST_Q, 3'(i), 2'b00}, dst_q[i]);
    end
    rd(ADR_SRC, src_q[0]);
    rd(ADR_SRC, src_q[0] & 32'h7FFF_FFFF);
    rd(ADR_DST, dst_q[0]);
    rd(ADR_DST, dst_q[0] & 32'h7FFF_FFFF);
    wr(ADR_DST, 32'hFFFF_FFFF);
    rd({WIN_DST_Q, 5'h00}, dst_q[0] & 32'h7FFF_FFFF);
    rd({WIN_SRC_Q, 5'h04}, src_q[1]);
    wr(ADR_CTRL, 32'h0);
    trace_one(1'b0, 28'($urandom), 3'h2, 28'($urandom));
    rd({WIN_SRC_Q, 5'h00}, src_q[0] & 32'h7FFF_FFFF);
    do_reset();
    rd({WIN_SRC_Q, 5'h04}, src_q[1] & 32'h7FFF_FFFF);
    rd({WIN_DST_Q, 5'h04}, dst_q[1] & 32'h7FFF_FFFF);
    rd(ADR_ASID_A, {24'h0, ida});
    chk({24'h0, sid_b}, {24'h0, idb});
    results();
  end
  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule
